// ---- idm_pkg.sv ----
/*
 * Shared constants, types and decode helpers for the internal data memory
 * map. Assumes one clock domain and a CPU core on the same clock that
 * issues one access at a time.
 */
package idm_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 256;

    localparam logic [7:0] UPPER_LIMIT = 8'h7F;
    localparam logic [7:0] BANK_BASE = 8'h00;
    localparam logic [7:0] BIT_BASE = 8'h20;
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [7:0] PSW_RESET = 8'h00;
    localparam logic [7:0] SP_SFR_ADDR = 8'h81;
    localparam logic [7:0] PSW_SFR_ADDR = 8'hD0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] STEP_ONE = 8'h01;
    localparam int BANK_LO_BIT = 3;
    localparam int BANK_HI_BIT = 4;
    localparam int BIT_ADDR_TOP = 7;

    typedef enum logic [2:0] {
        OP_DIRECT = 3'h0,
        OP_INDIRECT = 3'h1,
        OP_BIT = 3'h2,
        OP_PUSH = 3'h3,
        OP_POP = 3'h4,
        OP_XDATA_PTR = 3'h5,
        OP_XDATA_IND = 3'h6
    } op_e;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_INDEX = 5'h02,
        ST_ISSUE = 5'h04,
        ST_WAIT = 5'h08,
        ST_SFR = 5'h10
    } state_e;

    // Address of the first or second register of the given bank.
    function automatic logic [7:0] indexRegAddr(input logic [1:0] bank,
                                                input logic sel);
        indexRegAddr = BANK_BASE | {3'h0, bank, 2'h0, sel};
    endfunction : indexRegAddr

    function automatic logic [7:0] bitByteAddr(input logic [7:0] bitAddr);
        bitByteAddr = BIT_BASE + {4'h0, bitAddr[6:3]};
    endfunction : bitByteAddr

    function automatic logic [2:0] bitPos(input logic [7:0] bitAddr);
        bitPos = bitAddr[2:0];
    endfunction : bitPos

endpackage : idm_pkg

// ---- mem_port_if.sv ----
/*
 * Port bundle between the access controller and one byte-wide RAM.
 * Assumes read data appear one clock after an enabled read.
 */
`timescale 1ns/100ps
interface mem_port_if;
    logic en;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport ctrl (output en, output we, output addr, output wdata,
                  input rdata);
    modport mem (input en, input we, input addr, input wdata,
                 output rdata);
endinterface : mem_port_if

// ---- byte_ram.sv ----
/*
 * Byte-wide single-port RAM of 256 words with registered read data.
 * Assumes the controller drives the port on the same clock; read data
 * hold their value until the next enabled read or a reset, which clears them.
 */
`timescale 1ns/100ps
module byte_ram (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Access port
    mem_port_if.mem port
);
    logic [7:0] store [idm_pkg::MEM_DEPTH];
    logic [7:0] rdata_q;

    always_ff @(posedge clock) begin
        if (port.en && port.we) begin
            store[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rdata_q <= idm_pkg::BYTE_ZERO;
        end else if (port.en && !port.we) begin
            rdata_q <= store[port.addr];
        end
    end

    assign port.rdata = rdata_q;
endmodule : byte_ram

// ---- access_decode.sv ----
/*
 * Combinational classification of one resolved access: which space it
 * targets and at which byte. Assumes the effective address has already
 * been resolved from the pointer, stack pointer or request.
 */
`timescale 1ns/100ps
module access_decode (
    // Access description
    input wire idm_pkg::op_e op,
    input wire logic [7:0] effAddr,
    // Classification
    output logic toSfr,
    output logic toXram,
    output logic refused,
    output logic [7:0] memAddr
);
    always_comb begin
        // Only direct addressing is steered by the address value.
        toSfr = (op == idm_pkg::OP_DIRECT) &&
                (effAddr > idm_pkg::UPPER_LIMIT);
        toXram = (op == idm_pkg::OP_XDATA_PTR) ||
                 (op == idm_pkg::OP_XDATA_IND);
        // Bit addresses above the RAM range name register bits that
        // this block does not own, so they are answered as refused.
        refused = (op == idm_pkg::OP_BIT) &&
                  effAddr[idm_pkg::BIT_ADDR_TOP];
        if (op == idm_pkg::OP_BIT) begin
            memAddr = idm_pkg::bitByteAddr(effAddr);
        end else begin
            memAddr = effAddr;
        end
    end
endmodule : access_decode

// ---- internal_data_memory_map.sv ----
/*
 * Internal data memory map: register banks, bit area, upper RAM versus
 * special function registers, hardware stack and on-chip external RAM.
 * Assumes the CPU core on the same clock issues one access at a time
 * while ready is high and holds only dataPointer into the cycle after the request.
 */
`timescale 1ns/100ps
module internal_data_memory_map (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Access request from the CPU core
    input wire logic reqValid,
    input wire idm_pkg::op_e reqOp,
    input wire logic reqWrite,
    input wire logic [7:0] reqAddr,
    input wire logic reqIndexSel,
    input wire logic [7:0] reqWdata,
    input wire logic reqBit,
    input wire logic [15:0] dataPointer,
    output logic reqReady,
    // Answer to the CPU core
    output logic ansDone,
    output logic [7:0] ansRdata,
    output logic ansBit,
    output logic ansRefused,
    // Special function register space outside this block
    output logic sfrStrobe,
    output logic sfrWrite,
    output logic [7:0] sfrAddr,
    output logic [7:0] sfrWdata,
    input wire logic [7:0] sfrRdata,
    // Status
    output logic [7:0] stackPointer,
    output logic [7:0] programStatusWord,
    output logic [1:0] activeBank
);
    typedef struct packed {
        idm_pkg::state_e st;
        idm_pkg::op_e op;
        logic wr;
        logic [7:0] addr;
        logic idxSel;
        logic [7:0] wdata;
        logic bitVal;
        logic [7:0] tgt;
        logic tgtXram;
        logic [7:0] sp;
        logic [7:0] program_status_word;
        logic ready;
        logic done;
        logic [7:0] rdata;
        logic bitOut;
        logic refused;
        logic sfrStb;
        logic sfrWr;
        logic [7:0] sfrA;
        logic [7:0] sfrWd;
    } state_s;

    localparam state_s RESET_STATE = '{
        st: idm_pkg::ST_IDLE,
        op: idm_pkg::OP_DIRECT,
        wr: 1'b0,
        addr: idm_pkg::BYTE_ZERO,
        idxSel: 1'b0,
        wdata: idm_pkg::BYTE_ZERO,
        bitVal: 1'b0,
        tgt: idm_pkg::BYTE_ZERO,
        tgtXram: 1'b0,
        sp: idm_pkg::SP_RESET,
        program_status_word: idm_pkg::PSW_RESET,
        ready: 1'b1,
        done: 1'b0,
        rdata: idm_pkg::BYTE_ZERO,
        bitOut: 1'b0,
        refused: 1'b0,
        sfrStb: 1'b0,
        sfrWr: 1'b0,
        sfrA: idm_pkg::BYTE_ZERO,
        sfrWd: idm_pkg::BYTE_ZERO
    };

    state_s s_q;
    state_s s_d;

    mem_port_if idram ();
    mem_port_if xram ();

    logic [1:0] bank;
    logic [7:0] effAddr;
    logic [7:0] readByte;
    logic [7:0] modByte;
    logic decSfr;
    logic decXram;
    logic decRefused;
    logic [7:0] decAddr;

    byte_ram u_idram (
        .clock(clock),
        .reset_n(reset_n),
        .port(idram.mem)
    );

    byte_ram u_xram (
        .clock(clock),
        .reset_n(reset_n),
        .port(xram.mem)
    );

    access_decode u_decode (
        .op(s_q.op),
        .effAddr(effAddr),
        .toSfr(decSfr),
        .toXram(decXram),
        .refused(decRefused),
        .memAddr(decAddr)
    );

    // The two bank-select bits pick exactly one bank at any time.
    assign bank = {s_q.program_status_word[idm_pkg::BANK_HI_BIT],
                   s_q.program_status_word[idm_pkg::BANK_LO_BIT]};

    // Resolve the address before classification. Pointer reads issued in
    // the index state are valid here, one cycle later.
    always_comb begin
        unique case (s_q.op)
            idm_pkg::OP_INDIRECT,
            idm_pkg::OP_XDATA_IND: effAddr = idram.rdata;
            // Only the low byte of the data pointer reaches the 256 bytes.
            idm_pkg::OP_XDATA_PTR: effAddr = dataPointer[7:0];
            idm_pkg::OP_PUSH: effAddr = s_q.sp + idm_pkg::STEP_ONE;
            idm_pkg::OP_POP: effAddr = s_q.sp;
            default: effAddr = s_q.addr;
        endcase
    end

    assign readByte = s_q.tgtXram ? xram.rdata : idram.rdata;

    // Read-modify-write keeps the other seven bits of the bit-area byte.
    always_comb begin
        modByte = readByte;
        modByte[idm_pkg::bitPos(s_q.addr)] = s_q.bitVal;
    end

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.refused = 1'b0;
        s_d.sfrStb = 1'b0;
        idram.en = 1'b0;
        idram.we = 1'b0;
        idram.addr = idm_pkg::BYTE_ZERO;
        idram.wdata = idm_pkg::BYTE_ZERO;
        xram.en = 1'b0;
        xram.we = 1'b0;
        xram.addr = idm_pkg::BYTE_ZERO;
        xram.wdata = idm_pkg::BYTE_ZERO;
        unique case (s_q.st)
            idm_pkg::ST_IDLE: begin
                if (reqValid) begin
                    s_d.op = reqOp;
                    s_d.wr = reqWrite;
                    s_d.addr = reqAddr;
                    s_d.idxSel = reqIndexSel;
                    s_d.wdata = reqWdata;
                    s_d.bitVal = reqBit;
                    s_d.ready = 1'b0;
                    if (reqOp == idm_pkg::OP_INDIRECT ||
                        reqOp == idm_pkg::OP_XDATA_IND) begin
                        s_d.st = idm_pkg::ST_INDEX;
                    end else begin
                        s_d.st = idm_pkg::ST_ISSUE;
                    end
                end
            end
            idm_pkg::ST_INDEX: begin
                // Fetch the pointer from the active bank's register.
                idram.en = 1'b1;
                idram.addr = idm_pkg::indexRegAddr(bank, s_q.idxSel);
                s_d.st = idm_pkg::ST_ISSUE;
            end
            idm_pkg::ST_ISSUE: begin
                s_d.tgt = decAddr;
                s_d.tgtXram = decXram;
                if (decRefused) begin
                    s_d.done = 1'b1;
                    s_d.refused = 1'b1;
                    s_d.ready = 1'b1;
                    s_d.st = idm_pkg::ST_IDLE;
                end else if (decSfr) begin
                    if (s_q.addr == idm_pkg::SP_SFR_ADDR) begin
                        if (s_q.wr) begin
                            s_d.sp = s_q.wdata;
                        end else begin
                            s_d.rdata = s_q.sp;
                        end
                        s_d.done = 1'b1;
                        s_d.ready = 1'b1;
                        s_d.st = idm_pkg::ST_IDLE;
                    end else if (s_q.addr == idm_pkg::PSW_SFR_ADDR) begin
                        if (s_q.wr) begin
                            s_d.program_status_word = s_q.wdata;
                        end else begin
                            s_d.rdata = s_q.program_status_word;
                        end
                        s_d.done = 1'b1;
                        s_d.ready = 1'b1;
                        s_d.st = idm_pkg::ST_IDLE;
                    end else begin
                        s_d.sfrStb = 1'b1;
                        s_d.sfrWr = s_q.wr;
                        s_d.sfrA = s_q.addr;
                        s_d.sfrWd = s_q.wdata;
                        s_d.st = idm_pkg::ST_SFR;
                    end
                end else if (decXram) begin
                    xram.en = 1'b1;
                    xram.we = s_q.wr;
                    xram.addr = decAddr;
                    xram.wdata = s_q.wdata;
                    if (s_q.wr) begin
                        s_d.done = 1'b1;
                        s_d.ready = 1'b1;
                        s_d.st = idm_pkg::ST_IDLE;
                    end else begin
                        s_d.st = idm_pkg::ST_WAIT;
                    end
                end else begin
                    // Indirect, stack and low direct accesses all land in
                    // the full 256-byte internal RAM.
                    idram.en = 1'b1;
                    idram.addr = decAddr;
                    idram.wdata = s_q.wdata;
                    if (s_q.op == idm_pkg::OP_PUSH) begin
                        idram.we = 1'b1;
                        s_d.sp = effAddr;
                        s_d.done = 1'b1;
                        s_d.ready = 1'b1;
                        s_d.st = idm_pkg::ST_IDLE;
                    end else if (s_q.wr && s_q.op != idm_pkg::OP_BIT &&
                                 s_q.op != idm_pkg::OP_POP) begin
                        idram.we = 1'b1;
                        s_d.done = 1'b1;
                        s_d.ready = 1'b1;
                        s_d.st = idm_pkg::ST_IDLE;
                    end else begin
                        s_d.st = idm_pkg::ST_WAIT;
                    end
                end
            end
            idm_pkg::ST_WAIT: begin
                if (s_q.op == idm_pkg::OP_BIT) begin
                    s_d.bitOut = readByte[idm_pkg::bitPos(s_q.addr)];
                    if (s_q.wr) begin
                        idram.en = 1'b1;
                        idram.we = 1'b1;
                        idram.addr = s_q.tgt;
                        idram.wdata = modByte;
                    end
                end else begin
                    s_d.rdata = readByte;
                end
                if (s_q.op == idm_pkg::OP_POP) begin
                    s_d.sp = s_q.sp - idm_pkg::STEP_ONE;
                end
                s_d.done = 1'b1;
                s_d.ready = 1'b1;
                s_d.st = idm_pkg::ST_IDLE;
            end
            idm_pkg::ST_SFR: begin
                // The outside register space answers in the strobe cycle
                // itself; a slower register would need a wait line.
                s_d.rdata = s_q.sfrWr ? s_q.rdata : sfrRdata;
                s_d.done = 1'b1;
                s_d.ready = 1'b1;
                s_d.st = idm_pkg::ST_IDLE;
            end
            default: begin
                s_d = RESET_STATE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            s_q <= RESET_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign reqReady = s_q.ready;
    assign ansDone = s_q.done;
    assign ansRdata = s_q.rdata;
    assign ansBit = s_q.bitOut;
    assign ansRefused = s_q.refused;
    assign sfrStrobe = s_q.sfrStb;
    assign sfrWrite = s_q.sfrWr;
    assign sfrAddr = s_q.sfrA;
    assign sfrWdata = s_q.sfrWd;
    assign stackPointer = s_q.sp;
    assign programStatusWord = s_q.program_status_word;
    assign activeBank = {s_q.program_status_word[idm_pkg::BANK_HI_BIT],
                         s_q.program_status_word[idm_pkg::BANK_LO_BIT]};
endmodule : internal_data_memory_map

// ---- sfr_space_model.sv ----
/*
 * Behavioural model of the special function register space that lies
 * outside the memory map block. Assumes the block strobes one access at a
 * time and samples read data in the strobe cycle or the one after it.
 */
`timescale 1ns/100ps
module sfr_space_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Special function register port of the block
    input wire logic sfrStrobe,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata
);
    logic [7:0] regs [0:255];
    logic answering;
    logic [7:0] noise;

    // Outside the answer window the bus toggles, so stale data never match.
    assign sfrRdata = (sfrStrobe || answering) ? regs[sfrAddr] : noise;

    always_ff @(posedge clock) begin
        answering <= sfrStrobe && !sfrWrite && reset_n;
        if (!reset_n) begin
            noise <= 8'h5A;
        end else begin
            noise <= ~noise;
        end
        if (sfrStrobe && sfrWrite) begin
            regs[sfrAddr] <= sfrWdata;
        end
    end
endmodule : sfr_space_model

// ---- internal_data_memory_map_checker.sv ----
/*
 * Concurrent checks on the ports of the internal data memory map.
 * Assumes the single clock and the synchronous active-low reset.
 */
`timescale 1ns/100ps
module internal_data_memory_map_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Request and answer
    input wire logic reqValid,
    input wire idm_pkg::op_e reqOp,
    input wire logic [7:0] reqAddr,
    input wire logic reqReady,
    input wire logic ansDone,
    input wire logic ansRefused,
    // Special function register port and status
    input wire logic sfrStrobe,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] stackPointer,
    input wire logic [7:0] programStatusWord,
    input wire logic [1:0] activeBank
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence taken;
        reqValid && reqReady;
    endsequence
    sequence pushTaken;
        taken ##0 reqOp == idm_pkg::OP_PUSH;
    endsequence
    sequence popTaken;
        taken ##0 reqOp == idm_pkg::OP_POP;
    endsequence
    sequence upperDirect;
        taken ##0 reqOp == idm_pkg::OP_DIRECT && reqAddr > 8'h7F
            && reqAddr != 8'h81 && reqAddr != 8'hD0;
    endsequence

    AST_PUSH_STEP: assert property (pushTaken |-> ##2 ansDone
        && stackPointer == $past(stackPointer, 2) + 8'h01)
        else $error("push did not step the stack pointer up by one");
    AST_POP_STEP: assert property (popTaken |-> ##3 ansDone
        && stackPointer == $past(stackPointer, 3) - 8'h01)
        else $error("pop did not step the stack pointer down by one");
    AST_RESET_SP: assert property ($rose(reset_n) |->
        stackPointer == 8'h07)
        else $error("stack pointer not at its reset value");
    AST_BANK_FOLLOWS: assert property (activeBank ==
        programStatusWord[4:3])
        else $error("active bank differs from the status word bits");
    AST_DIRECT_UPPER: assert property (upperDirect |-> ##2 sfrStrobe
        && sfrAddr == $past(reqAddr, 2))
        else $error("direct upper access not sent to register space");
    AST_DIRECT_LOWER: assert property (taken ##0
        reqOp == idm_pkg::OP_DIRECT && reqAddr <= 8'h7F |-> ##1 !sfrStrobe[*3])
        else $error("direct lower access reached register space");
    AST_INDIRECT_RAM: assert property (taken ##0
        reqOp == idm_pkg::OP_INDIRECT |-> ##1 !sfrStrobe[*4])
        else $error("indirect access reached register space");
    AST_BIT_REFUSED: assert property (taken ##0
        reqOp == idm_pkg::OP_BIT && reqAddr[7] |-> ##2 ansDone && ansRefused)
        else $error("bit address above the bit area not refused");
    AST_BIT_DONE: assert property (taken ##0
        reqOp == idm_pkg::OP_BIT && !reqAddr[7] |-> ##3 ansDone && !ansRefused)
        else $error("bit access in the bit area not answered in time");
    AST_BUSY: assert property (taken |=> !reqReady)
        else $error("ready stayed high after a request was taken");
endmodule : internal_data_memory_map_checker

bind internal_data_memory_map internal_data_memory_map_checker chk (
    .clock(clock), .reset_n(reset_n), .reqValid(reqValid), .reqOp(reqOp),
    .reqAddr(reqAddr), .reqReady(reqReady), .ansDone(ansDone),
    .ansRefused(ansRefused), .sfrStrobe(sfrStrobe), .sfrAddr(sfrAddr),
    .stackPointer(stackPointer), .programStatusWord(programStatusWord),
    .activeBank(activeBank)
);

// ---- internal_data_memory_map_test.sv ----
/*
 * Self-checking testbench of the internal data memory map with a model of
 * the register space. Assumes the package and design files compile first.
 */
`timescale 1ns/100ps
module internal_data_memory_map_test;
    logic clock, reset_n, reqValid, reqWrite, reqIndexSel, reqBit;
    idm_pkg::op_e reqOp;
    logic [7:0] reqAddr, reqWdata, sfrWdata, sfrRdata, sfrAddr;
    logic [15:0] dataPointer;
    logic reqReady, ansDone, ansBit, ansRefused, sfrStrobe, sfrWrite;
    logic [7:0] ansRdata, stackPointer, programStatusWord;
    logic [1:0] activeBank;
    int badCount;
    int compares;

    internal_data_memory_map dut (
        .clock(clock), .reset_n(reset_n), .reqValid(reqValid),
        .reqOp(reqOp), .reqWrite(reqWrite), .reqAddr(reqAddr),
        .reqIndexSel(reqIndexSel), .reqWdata(reqWdata), .reqBit(reqBit),
        .dataPointer(dataPointer), .reqReady(reqReady), .ansDone(ansDone),
        .ansRdata(ansRdata), .ansBit(ansBit), .ansRefused(ansRefused),
        .sfrStrobe(sfrStrobe), .sfrWrite(sfrWrite), .sfrAddr(sfrAddr),
        .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
        .stackPointer(stackPointer), .programStatusWord(programStatusWord),
        .activeBank(activeBank)
    );

    sfr_space_model sfr (
        .clock(clock), .reset_n(reset_n), .sfrStrobe(sfrStrobe),
        .sfrWrite(sfrWrite), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
        .sfrRdata(sfrRdata)
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            badCount++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask : check

    task automatic access(input idm_pkg::op_e op, input logic wr,
                          input logic [7:0] addr, input logic sel,
                          input logic [7:0] wd, input logic b);
        int i;
        @(negedge clock);
        reqValid = 1'b1;
        reqOp = op;
        reqWrite = wr;
        reqAddr = addr;
        reqIndexSel = sel;
        reqWdata = wd;
        reqBit = b;
        @(negedge clock);
        reqValid = 1'b0;
        for (i = 0; i < 8 && ansDone !== 1'b1; i++) @(negedge clock);
        check({7'h00, ansDone}, 8'h01);
    endtask : access

    task automatic wrByte(input logic [7:0] addr, input logic [7:0] wd);
        access(idm_pkg::OP_DIRECT, 1'b1, addr, 1'b0, wd, 1'b0);
    endtask : wrByte

    task automatic rdByte(input logic [7:0] addr, input logic [7:0] exp);
        access(idm_pkg::OP_DIRECT, 1'b0, addr, 1'b0, 8'h00, 1'b0);
        check(ansRdata, exp);
    endtask : rdByte

    task automatic testStack;
        check(stackPointer, 8'h07);
        access(idm_pkg::OP_PUSH, 1'b1, 8'h00, 1'b0, 8'h5A, 1'b0);
        check(stackPointer, 8'h08);
        rdByte(8'h08, 8'h5A);
        access(idm_pkg::OP_POP, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0);
        check(ansRdata, 8'h5A);
        check(stackPointer, 8'h07);
        wrByte(8'h81, 8'hFF);
        access(idm_pkg::OP_PUSH, 1'b1, 8'h00, 1'b0, 8'h3C, 1'b0);
        check(stackPointer, 8'h00);
        rdByte(8'h00, 8'h3C);
        $display("stack test done");
    endtask : testStack

    task automatic testBanks;
        logic [7:0] b;
        // Each bank points at its own bytes, so a wrong bank reads wrong data.
        for (b = 8'h00; b < 8'h04; b++) begin
            wrByte(8'hD0, b << 3);
            check({6'h00, activeBank}, b);
            wrByte(b << 3, 8'h40 + b);
            wrByte((b << 3) + 8'h01, 8'h60 + b);
            wrByte(8'h40 + b, 8'hA0 + b);
            wrByte(8'h60 + b, 8'hC0 + b);
        end
        for (b = 8'h00; b < 8'h04; b++) begin
            wrByte(8'hD0, b << 3);
            access(idm_pkg::OP_INDIRECT, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0);
            check(ansRdata, 8'hA0 + b);
            access(idm_pkg::OP_INDIRECT, 1'b0, 8'h00, 1'b1, 8'h00, 1'b0);
            check(ansRdata, 8'hC0 + b);
        end
        wrByte(8'hD0, 8'h00);
        $display("bank test done");
    endtask : testBanks

    task automatic testUpper;
        wrByte(8'h00, 8'h90);
        access(idm_pkg::OP_INDIRECT, 1'b1, 8'h00, 1'b0, 8'h5C, 1'b0);
        wrByte(8'h90, 8'h77);
        check(sfrAddr, 8'h90);
        check(sfrWdata, 8'h77);
        check({7'h00, sfrWrite}, 8'h01);
        rdByte(8'h90, 8'h77);
        access(idm_pkg::OP_INDIRECT, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0);
        check(ansRdata, 8'h5C);
        $display("upper space test done");
    endtask : testUpper

    task automatic testBits;
        wrByte(8'h22, 8'h00);
        wrByte(8'h13, 8'h5E);
        wrByte(8'h2F, 8'h00);
        access(idm_pkg::OP_BIT, 1'b1, 8'h13, 1'b0, 8'h00, 1'b1);
        rdByte(8'h22, 8'h08);
        access(idm_pkg::OP_BIT, 1'b0, 8'h13, 1'b0, 8'h00, 1'b0);
        check({7'h00, ansBit}, 8'h01);
        rdByte(8'h13, 8'h5E);
        access(idm_pkg::OP_BIT, 1'b1, 8'h7F, 1'b0, 8'h00, 1'b1);
        rdByte(8'h2F, 8'h80);
        access(idm_pkg::OP_BIT, 1'b1, 8'h80, 1'b0, 8'h00, 1'b1);
        check({7'h00, ansRefused}, 8'h01);
        $display("bit test done");
    endtask : testBits

    task automatic testXram;
        wrByte(8'h34, 8'h11);
        dataPointer = 16'hAB34;
        access(idm_pkg::OP_XDATA_PTR, 1'b1, 8'h00, 1'b0, 8'h99, 1'b0);
        wrByte(8'h01, 8'h34);
        access(idm_pkg::OP_XDATA_IND, 1'b0, 8'h00, 1'b1, 8'h00, 1'b0);
        check(ansRdata, 8'h99);
        rdByte(8'h34, 8'h11);
        $display("external ram test done");
    endtask : testXram

    task automatic endOfTest;
        $display("comparisons %0d mismatches %0d", compares, badCount);
        if (badCount == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : endOfTest

    initial begin
        #40000;
        badCount++;
        endOfTest();
    end

    initial begin
        reset_n = 1'b0;
        reqValid = 1'b0;
        reqOp = idm_pkg::OP_DIRECT;
        reqWrite = 1'b0;
        reqAddr = 8'h00;
        reqIndexSel = 1'b0;
        reqWdata = 8'h00;
        reqBit = 1'b0;
        dataPointer = 16'h0000;
        repeat (16) @(negedge clock);
        reset_n = 1'b1;
        check(programStatusWord, 8'h00);
        check({7'h00, reqReady}, 8'h01);
        testStack();
        testBanks();
        testUpper();
        testBits();
        testXram();
        endOfTest();
    end
endmodule : internal_data_memory_map_test
